/* core/pajs_sequencer.v */
// Pump unjam sequencer: reverse/stop/forward/stop cycles, counting, fault.
// Assumes all inputs synchronous to sys_clk; settings held stable by user.
`timescale 1ns/1ps
`include "pajs_consts.vh"

// Summary of operation
// - Cycle order: reverse, stop, forward, stop, with each phase's time and force.
// - A sequence repeats the cycle cycles_per_sequence times, at least once (zero gives one cycle).
// - Requested while running: stop the motor first, then reverse.
// - Sequence counter increments on every start, external or automatic.
// - Counter clears when the interval expires with no new sequence.
// - Counter at maximum raises unjam_limit_fault and coasts the motor.
// - After an automatic sequence, restart if the start order remains.
// - Input trigger, hardwired or two-wire level: start at end if run order.
// - Two-wire transition or three-wire: no start; release trigger, new run.
// - Line-channel trigger: motor state after sequence follows command word.
// - Discrete-input trigger only acts with local or terminal command channel.
// - Automatic source: off (default) or current overload request.
// - Overload fires after current at or above level for dwell delay, 10 s.
// - Dwell timer clears when current falls below the level.
// - Overload level is a percentage of nominal current, default 80.
// - External trigger returning to zero during a sequence aborts it.
// - Line trigger only in operation-enabled; halt beats a request.
// - Reverse and forward times set in seconds, default 5 s each.
// - Force presets: profile, low, very low; profile needs contactor reversal.
module pajs_sequencer #(
	parameter CYC_PER_S = `PAJS_CYC_PER_S,
	parameter CYC_PER_MS = `PAJS_CYC_PER_MS
)(
	input wire sys_clk,
	input wire rst,
	input wire [1:0] external_unjam_source,
	input wire auto_unjam_source,
	input wire [7:0] reverse_phase_time,
	input wire [1:0] reverse_phase_force,
	input wire [7:0] pause_phase_time,
	input wire [7:0] forward_phase_time,
	input wire [1:0] forward_phase_force,
	input wire [7:0] cycles_per_sequence,
	input wire [7:0] max_sequences,
	input wire [15:0] interval_time,
	input wire [7:0] overcurrent_dwell_delay,
	input wire [7:0] overcurrent_level,
	input wire [15:0] motor_current,
	input wire [15:0] nominal_current,
	input wire discrete_input,
	input wire line_unjam_bit,
	input wire local_channel,
	input wire [1:0] wire_mode,
	input wire run_order,
	input wire line_run_cmd,
	input wire op_enabled,
	input wire halt_bit,
	input wire contactor_reverse,
	input wire motor_running,
	input wire fault_clear,
	output reg [2:0] drive_cmd,
	output reg [1:0] drive_force,
	output reg seq_active,
	output reg [7:0] seq_count,
	output reg unjam_limit_fault,
	output reg seq_done
);

// ----------------------------------------
// States
// ----------------------------------------
localparam S_IDLE = 7'h01;
localparam S_PRESTOP = 7'h02;
localparam S_REV = 7'h04;
localparam S_STOP1 = 7'h08;
localparam S_FWD = 7'h10;
localparam S_STOP2 = 7'h20;
localparam S_WAIT = 7'h40;

reg [6:0] state_reg;
reg [31:0] tick_reg;
reg [31:0] phase_reg;
reg [7:0] cycle_reg;
reg auto_src_reg;
reg [31:0] dwell_reg;
reg [31:0] ivl_reg;
reg ivl_run_reg;
reg release_reg;

function [31:0] secs;
	input [15:0] s;
	begin
		secs = s * CYC_PER_S;
	end
endfunction

// Profile only with contactor reversal; else fall back to low force
function [1:0] force_ok;
	input [1:0] f;
	input c;
	begin
		if (f == `PAJS_FORCE_PROFILE && !c)
			force_ok = `PAJS_FORCE_LOW;
		else if (f > `PAJS_FORCE_VLOW)
			force_ok = `PAJS_FORCE_LOW;
		else
			force_ok = f;
	end
endfunction

// ----------------------------------------
// Trigger decode
// ----------------------------------------
wire di_trig = external_unjam_source == `PAJS_EXT_DI && discrete_input &&
	local_channel == `PAJS_CHAN_LOCAL;
wire line_trig = external_unjam_source == `PAJS_EXT_LINE && line_unjam_bit &&
	op_enabled && !halt_bit;
wire ext_trig = di_trig || line_trig;
// Current at or above level: times 100 vs nominal times percent, no divider
wire [31:0] cur_scaled = {16'h0000, motor_current} * `PAJS_PCT_FULL;
wire [31:0] lvl_scaled = {16'h0000, nominal_current} *
	{24'h000000, overcurrent_level};
wire over = cur_scaled >= lvl_scaled;
wire auto_trig = auto_unjam_source == `PAJS_AUTO_OVL &&
	dwell_reg >= secs({8'h00, overcurrent_dwell_delay});
// Trigger held is not a new request; a fresh one is needed after release
wire start_req = !unjam_limit_fault && state_reg == S_IDLE &&
	((ext_trig && !release_reg) || auto_trig);
wire ext_gone = !auto_src_reg && !ext_trig;
wire phase_end = tick_reg >= phase_reg;
wire last_cycle = cycle_reg + 8'h01 >= cycles_per_sequence;
wire hit_max = seq_count + 8'h01 >= max_sequences;

// ----------------------------------------
// Overload dwell timer
// ----------------------------------------
always @(posedge sys_clk)
begin
	if (rst || !over || auto_unjam_source == `PAJS_AUTO_OFF ||
		state_reg != S_IDLE)
		dwell_reg <= 32'h0;
	else if (!auto_trig)
		dwell_reg <= dwell_reg + 32'h1;
end

// ----------------------------------------
// Sequence counter and supervision interval
// ----------------------------------------
always @(posedge sys_clk)
begin
	if (rst)
	begin
		seq_count <= 8'h00;
		ivl_reg <= 32'h0;
		ivl_run_reg <= 1'b0;
		unjam_limit_fault <= 1'b0;
	end
	else if (start_req)
	begin
		seq_count <= seq_count + 8'h01;
		ivl_reg <= 32'h0;
		ivl_run_reg <= 1'b1;
		if (hit_max)
			unjam_limit_fault <= 1'b1;
	end
	else
	begin
		if (fault_clear)
			unjam_limit_fault <= 1'b0;
		if (ivl_run_reg)
		begin
			if (ivl_reg >= secs(interval_time))
			begin
				seq_count <= 8'h00;
				ivl_run_reg <= 1'b0;
			end
			else
				ivl_reg <= ivl_reg + 32'h1;
		end
	end
end

// ----------------------------------------
// Phase sequencer
// ----------------------------------------
always @(posedge sys_clk)
begin
	if (rst)
	begin
		state_reg <= S_IDLE;
		tick_reg <= 32'h0;
		phase_reg <= 32'h0;
		cycle_reg <= 8'h00;
		auto_src_reg <= 1'b0;
		release_reg <= 1'b0;
		seq_done <= 1'b0;
	end
	else
	begin
		seq_done <= 1'b0;
		tick_reg <= tick_reg + 32'h1;
		if (!ext_trig)
			release_reg <= 1'b0;
		case (state_reg)
		S_IDLE:
			if (start_req && !hit_max)
			begin
				auto_src_reg <= !(ext_trig && !release_reg);
				cycle_reg <= 8'h00;
				tick_reg <= 32'h0;
				state_reg <= S_PRESTOP;
			end
		S_PRESTOP:
			if (!motor_running && drive_cmd != `PAJS_DRV_RUN)
			begin
				tick_reg <= 32'h0;
				phase_reg <= secs({8'h00, reverse_phase_time});
				state_reg <= S_REV;
			end
		S_REV, S_STOP1, S_FWD, S_STOP2:
			if (phase_end)
			begin
				tick_reg <= 32'h0;
				case (state_reg)
				S_REV:
				begin
					phase_reg <= secs({8'h00, pause_phase_time});
					state_reg <= S_STOP1;
				end
				S_STOP1:
				begin
					phase_reg <= secs({8'h00, forward_phase_time});
					state_reg <= S_FWD;
				end
				S_FWD:
				begin
					phase_reg <= secs({8'h00, pause_phase_time});
					state_reg <= S_STOP2;
				end
				default:
					if (last_cycle)
					begin
						state_reg <= S_WAIT;
						seq_done <= 1'b1;
					end
					else
					begin
						cycle_reg <= cycle_reg + 8'h01;
						phase_reg <= secs({8'h00, reverse_phase_time});
						state_reg <= S_REV;
					end
				endcase
			end
		S_WAIT:
		begin
			release_reg <= !auto_src_reg && ext_trig;
			state_reg <= S_IDLE;
		end
		default:
			state_reg <= S_IDLE;
		endcase
		// Trigger release mid-sequence aborts; fault also ends it
		if (state_reg != S_IDLE && state_reg != S_WAIT &&
			(ext_gone || unjam_limit_fault))
			state_reg <= S_IDLE;
	end
end

// ----------------------------------------
// Post-sequence restart permission
// ----------------------------------------
reg restart_ok;
always @*
begin
	restart_ok = 1'b0;
	if (auto_src_reg)
		restart_ok = run_order;
	else if (external_unjam_source == `PAJS_EXT_LINE)
		restart_ok = line_run_cmd && !halt_bit;
	else if (wire_mode == `PAJS_WIRE_HARD ||
		wire_mode == `PAJS_WIRE_2LEVEL)
		restart_ok = run_order;
	else
		restart_ok = 1'b0;
end

// Restart held off until a new run order in edge-sensed modes
reg hold_reg;
reg run_d_reg;
always @(posedge sys_clk)
begin
	if (rst)
	begin
		hold_reg <= 1'b0;
		run_d_reg <= 1'b0;
	end
	else
	begin
		run_d_reg <= run_order;
		if (state_reg == S_WAIT)
			hold_reg <= !restart_ok;
		else if (run_order && !run_d_reg && !ext_trig)
			hold_reg <= 1'b0;
	end
end

// ----------------------------------------
// Drive outputs
// ----------------------------------------
always @(posedge sys_clk)
begin
	if (rst)
	begin
		drive_cmd <= `PAJS_DRV_OFF;
		drive_force <= `PAJS_FORCE_LOW;
		seq_active <= 1'b0;
	end
	else
	begin
		seq_active <= state_reg != S_IDLE && state_reg != S_WAIT;
		drive_force <= `PAJS_FORCE_LOW;
		if (unjam_limit_fault)
			drive_cmd <= `PAJS_DRV_OFF;
		else
			case (state_reg)
			S_PRESTOP, S_STOP1, S_STOP2:
				drive_cmd <= `PAJS_DRV_BRAKE;
			S_REV:
			begin
				drive_cmd <= `PAJS_DRV_REV;
				drive_force <= force_ok(reverse_phase_force,
					contactor_reverse);
			end
			S_FWD:
			begin
				drive_cmd <= `PAJS_DRV_FWD;
				drive_force <= force_ok(forward_phase_force,
					contactor_reverse);
			end
			default:
				drive_cmd <= (state_reg == S_WAIT ? restart_ok :
					!hold_reg && run_order) ?
					`PAJS_DRV_RUN : `PAJS_DRV_OFF;
			endcase
	end
end

endmodule // pajs_sequencer

/* core/pajs_consts.vh */
// Constants for the pump unjam sequencer.
// Assumes a 200 MHz system clock; times are held in seconds or ms.
`ifndef PAJS_CONSTS_VH
`define PAJS_CONSTS_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PAJS_CLK_HZ 200000000
`define PAJS_CYC_PER_MS (`PAJS_CLK_HZ / 1000)
`define PAJS_CYC_PER_S `PAJS_CLK_HZ
`define PAJS_DEF_DWELL_S 8'h0A
`define PAJS_DEF_PHASE_S 8'h05
`define PAJS_DEF_LEVEL_PCT 8'h50
`define PAJS_DEF_CYCLES 8'h01
`define PAJS_DEF_MAXSEQ 8'h03
`define PAJS_PCT_FULL 32'h00000064
// ----------------------------------------
// Selector encodings
// ----------------------------------------
`define PAJS_EXT_NONE 2'h0
`define PAJS_EXT_DI 2'h1
`define PAJS_EXT_LINE 2'h2
`define PAJS_AUTO_OFF 1'h0
`define PAJS_AUTO_OVL 1'h1
`define PAJS_FORCE_PROFILE 2'h0
`define PAJS_FORCE_LOW 2'h1
`define PAJS_FORCE_VLOW 2'h2
`define PAJS_WIRE_HARD 2'h0
`define PAJS_WIRE_2LEVEL 2'h1
`define PAJS_WIRE_2TRANS 2'h2
`define PAJS_WIRE_3WIRE 2'h3
`define PAJS_DRV_OFF 3'h0
`define PAJS_DRV_BRAKE 3'h1
`define PAJS_DRV_REV 3'h2
`define PAJS_DRV_FWD 3'h3
`define PAJS_DRV_RUN 3'h4
`define PAJS_CHAN_LOCAL 1'h1
`endif

/* tb/pajs_motor_model.sv */
// Power stage model: reports motion while run is commanded, slow coast-down.
// Assumes drive_cmd from the sequencer on the same clock.
`timescale 1ns/1ps
`include "pajs_consts.vh"
module pajs_motor_model #(
	parameter LAG = 4
)(
	input wire sys_clk,
	input wire rst,
	input wire [2:0] drive_cmd,
	output wire motor_running
);
	reg [3:0] spin_reg;
	assign motor_running = spin_reg != 4'h0;
	// ----------------------------------------
	// Spin state
	// ----------------------------------------
	// Slow stop, so the prestop wait is really exercised
	always @(posedge sys_clk)
	begin
		if (rst)
			spin_reg <= 4'h0;
		else if (drive_cmd == `PAJS_DRV_RUN)
			spin_reg <= LAG;
		else if (spin_reg != 4'h0)
			spin_reg <= spin_reg - 4'h1;
	end
endmodule // pajs_motor_model

/* tb/pajs_monitor.sv */
// Checker for the unjam sequencer ports.
// Assumes binding into pajs_sequencer; one clock, sync reset.
`timescale 1ns/1ps
`include "pajs_consts.vh"
module pajs_monitor #(
	parameter CYC_PER_S = 1
)(
	input wire sys_clk,
	input wire rst,
	input wire [1:0] external_unjam_source,
	input wire [7:0] reverse_phase_time,
	input wire line_unjam_bit,
	input wire contactor_reverse,
	input wire [2:0] drive_cmd,
	input wire [1:0] drive_force,
	input wire seq_active,
	input wire [7:0] seq_count,
	input wire unjam_limit_fault,
	input wire seq_done
);
	reg [31:0] rev_len_reg;
	// ----------------------------------------
	// Helper and properties
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	always @(posedge sys_clk)
	begin
		if (rst || drive_cmd != `PAJS_DRV_REV)
			rev_len_reg <= 0;
		else
			rev_len_reg <= rev_len_reg + 1;
	end
	AST_FAULT_COAST: assert property (
		unjam_limit_fault && $past(unjam_limit_fault)
		|-> drive_cmd == `PAJS_DRV_OFF && !seq_active)
		else $error("drive not coasting in fault");
	AST_CNT_STEP: assert property (
		$changed(seq_count) && seq_count != 8'h00
		|-> seq_count == $past(seq_count) + 8'h01)
		else $error("counter jumped");
	AST_ABORT: assert property (
		$fell(line_unjam_bit) && seq_active
		&& external_unjam_source == `PAJS_EXT_LINE |-> ##[1:3] !seq_active)
		else $error("no abort on trigger drop");
	AST_PRESTOP: assert property (
		$rose(seq_active) |-> drive_cmd == `PAJS_DRV_BRAKE)
		else $error("sequence did not open with stop");
	AST_REV_AFTER_STOP: assert property (
		$changed(drive_cmd) && drive_cmd == `PAJS_DRV_REV
		|-> $past(drive_cmd) == `PAJS_DRV_BRAKE)
		else $error("reverse not after stop");
	AST_FWD_AFTER_STOP: assert property (
		$changed(drive_cmd) && drive_cmd == `PAJS_DRV_FWD
		|-> $past(drive_cmd) == `PAJS_DRV_BRAKE)
		else $error("forward not after stop");
	AST_FORCE_FALLBACK: assert property (
		drive_cmd == `PAJS_DRV_REV && !contactor_reverse
		|-> drive_force != `PAJS_FORCE_PROFILE)
		else $error("profile force without contactor");
	AST_REV_LEN: assert property (
		drive_cmd == `PAJS_DRV_BRAKE && $past(drive_cmd) == `PAJS_DRV_REV
		|-> rev_len_reg == reverse_phase_time * CYC_PER_S + 1)
		else $error("reverse phase length wrong");
	COV_DONE: cover property (seq_done);
	COV_FAULT: cover property ($rose(unjam_limit_fault));
	COV_START: cover property ($rose(seq_active));
endmodule // pajs_monitor
bind pajs_sequencer pajs_monitor #(.CYC_PER_S(CYC_PER_S)) mon_i (.*);

/* tb/tb.sv */
// Self-checking bench for the unjam sequencer with a motor model.
// Assumes a shortened second of 4 cycles.
`timescale 1ns/1ps
`include "pajs_consts.vh"
module tb;
	reg sys_clk = 1'b0, rst = 1'b1, auto_unjam_source = 1'b0;
	reg [1:0] external_unjam_source = `PAJS_EXT_DI;
	reg [1:0] wire_mode = `PAJS_WIRE_HARD;
	reg [1:0] reverse_phase_force = `PAJS_FORCE_PROFILE;
	reg [1:0] forward_phase_force = `PAJS_FORCE_VLOW;
	reg [7:0] reverse_phase_time = 8'h01, pause_phase_time = 8'h01;
	reg [7:0] forward_phase_time = 8'h02, cycles_per_sequence = 8'h02;
	reg [7:0] max_sequences = 8'h03, overcurrent_dwell_delay = 8'h02;
	reg [7:0] overcurrent_level = 8'h50, revs = 8'h00;
	reg [15:0] interval_time = 16'h0032, motor_current = 16'h0000;
	reg [15:0] nominal_current = 16'h0064;
	reg discrete_input = 1'b0, line_unjam_bit = 1'b0, halt_bit = 1'b0;
	reg local_channel = 1'b1, run_order = 1'b1, line_run_cmd = 1'b0;
	reg op_enabled = 1'b1, contactor_reverse = 1'b0, fault_clear = 1'b0;
	reg [2:0] last_cmd;
	wire [2:0] drive_cmd;
	wire [1:0] drive_force;
	wire [7:0] seq_count;
	wire motor_running, seq_active, unjam_limit_fault, seq_done;
	integer failures = 0, total_checks = 0, i;
	// ----------------------------------------
	// Instances and helpers
	// ----------------------------------------
	pajs_sequencer #(.CYC_PER_S(4), .CYC_PER_MS(1)) pajs_sequencer_i (.*);
	pajs_motor_model pajs_motor_model_i (.*);
	always #2.5 sys_clk = ~sys_clk;
	task check(input [7:0] seen, input [7:0] exp);
	begin
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	end
	endtask
	task tick(input integer n);
	begin
		repeat (n) @(posedge sys_clk);
		#1;
	end
	endtask
	task wait_done;
	begin
		for (i = 0; i < 2000 && seq_done !== 1'b1; i = i + 1)
			tick(1);
		if (seq_done !== 1'b1)
			failures = failures + 1;
		tick(2);
	end
	endtask
	task give_verdict;
	begin
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// Counts reverse phases; motor must be still when one opens
	always @(posedge sys_clk)
	begin
		last_cmd <= drive_cmd;
		if (drive_cmd === `PAJS_DRV_REV && last_cmd !== `PAJS_DRV_REV)
		begin
			revs <= revs + 8'h01;
			check(motor_running, 8'h00);
		end
	end
	initial
	begin
		#20000;
		failures = failures + 1;
		give_verdict;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		tick(12);
		rst = 1'b0;
		discrete_input = 1'b1;
		wait_done;
		check(revs, 8'h02);
		check(seq_count, 8'h01);
		check(drive_cmd, `PAJS_DRV_RUN);
		discrete_input = 1'b0;
		wire_mode = `PAJS_WIRE_3WIRE;
		tick(20);
		discrete_input = 1'b1;
		wait_done;
		check(seq_count, 8'h02);
		check(drive_cmd, `PAJS_DRV_OFF);
		discrete_input = 1'b0;
		local_channel = 1'b0;
		tick(2);
		discrete_input = 1'b1;
		tick(10);
		check(seq_count, 8'h02);
		discrete_input = 1'b0;
		local_channel = 1'b1;
		tick(2);
		discrete_input = 1'b1;
		tick(4);
		check(unjam_limit_fault, 8'h01);
		check(drive_cmd, `PAJS_DRV_OFF);
		discrete_input = 1'b0;
		fault_clear = 1'b1;
		tick(1);
		fault_clear = 1'b0;
		tick(210);
		check(seq_count, 8'h00);
		external_unjam_source = `PAJS_EXT_LINE;
		halt_bit = 1'b1;
		line_unjam_bit = 1'b1;
		tick(10);
		check(seq_active, 8'h00);
		line_unjam_bit = 1'b0;
		halt_bit = 1'b0;
		tick(2);
		line_unjam_bit = 1'b1;
		tick(12);
		check(seq_active, 8'h01);
		line_unjam_bit = 1'b0;
		tick(4);
		check(seq_active, 8'h00);
		tick(2);
		line_unjam_bit = 1'b1;
		line_run_cmd = 1'b1;
		wait_done;
		check(drive_cmd, `PAJS_DRV_RUN);
		line_unjam_bit = 1'b0;
		external_unjam_source = `PAJS_EXT_NONE;
		tick(210);
		auto_unjam_source = `PAJS_AUTO_OVL;
		motor_current = 16'h0050;
		tick(5);
		motor_current = 16'h004F;
		tick(1);
		motor_current = 16'h0050;
		tick(6);
		check(seq_count, 8'h00);
		tick(6);
		check(seq_count, 8'h01);
		motor_current = 16'h0000;
		wait_done;
		check(drive_cmd, `PAJS_DRV_RUN);
		give_verdict;
	end
endmodule // tb
